/* File: tb/tb_top.sv */
// Self-checking bench for the VCO calibration and ADC configuration bank.
`timescale 1ns/1ps
`include "vco_cfg_defs.svh"

module tb_top;
  import vco_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk;
  logic rst_n;
  reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic upd;
  logic [7:0] dly_in;
  logic [7:0] dly_out;
  logic dly_sh;
  vco_sel_s cal_sel;
  logic [8:0] man_band;
  logic man_core;
  vco_sel_s vsel;
  logic [14:0] settle;
  logic lvl;
  logic adc_en;
  logic adc_clk;
  logic [2:0] mute1;
  logic [2:0] mute2;
  logic [5:0] rtrim;
  logic signed [4:0] ftrim;
  logic [7:0] adc_code;
  logic [8:0] temp;
  int miscompares = 0;
  int samples_checked = 0;
  logic [14:0] addrs [16] = '{15'h0035, 15'h0039, 15'h003A, 15'h003B,
    15'h003C, 15'h003D, 15'h003E, 15'h003F, 15'h0040, 15'h0041, 15'h0042,
    15'h0044, 15'h0045, 15'h004B, 15'h004D, 15'h0050};

  vco_cal_adc_config_regs vco_cal_adc_config_regs_i (
    .clk_in(clk), .rst_n_in(rst_n), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .buffer_update_in(upd), .delay_ctrl_in(dly_in),
    .delay_ctrl_out(dly_out), .delay_ctrl_shadow_en_out(dly_sh),
    .cal_vco_sel_in(cal_sel), .manual_band_value_in(man_band),
    .manual_core_value_in(man_core), .vco_sel_out(vsel),
    .band_core_settle_count_out(settle),
    .output_logic_level_sel_out(lvl), .adc_enable_out(adc_en),
    .adc_clk_out(adc_clk), .output_one_mute_out(mute1),
    .output_two_mute_out(mute2), .cal_voltage_rising_trim_out(rtrim),
    .cal_voltage_falling_trim_out(ftrim), .adc_code_in(adc_code),
    .chip_temperature_out(temp)
  );

  // ----------------------------------------------------------------------
  // Clock and helper tasks
  // ----------------------------------------------------------------------
  // The 40 MHz clock toggles every half period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Every task except report_and_stop is entered and left 2 ns after a rising edge.
  task automatic cyc(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A write lets one idle cycle pass so the strobe never rises twice at once.
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc();
    req.wr = 1'b0;
    cyc();
  endtask

  // A read waits a bounded time for the valid pulse and compares its data.
  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    int n;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc();
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      cyc();
      n++;
    end
    check({7'h00, rvalid}, 16'h0001);
    check({8'h00, rdata}, {8'h00, exp});
    cyc();
  endtask

  // Measures high time and full period of the ADC clock in clock cycles.
  task automatic adc_period(input int div);
    int k;
    int h;
    int n;
    k = 0;
    while (adc_clk !== 1'b0 && k < 200) begin
      cyc();
      k++;
    end
    while (adc_clk !== 1'b1 && k < 400) begin
      cyc();
      k++;
    end
    h = 0;
    while (adc_clk === 1'b1 && h < 200) begin
      cyc();
      h++;
    end
    n = h;
    while (adc_clk !== 1'b1 && n < 400) begin
      cyc();
      n++;
    end
    check(h[15:0], 16'(2 * div + 1));
    check(n[15:0], 16'(4 * div + 2));
  endtask

  task automatic pulse_update();
    upd = 1'b1;
    cyc();
    upd = 1'b0;
    cyc(4);
  endtask

  task automatic endtest(input string name);
    $display("test %s finished, %0d mismatches so far", name, miscompares);
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The watchdog cuts a hung run short and counts it as a mismatch.
  initial begin
    #(25 * 20000);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  // Main sequence of register accesses and port checks.
  initial begin
    logic [2:0] m;
    logic [15:0] ex;
    rst_n = 1'b0;
    req = '0;
    upd = 1'b0;
    dly_in = 8'h00;
    cal_sel = '{core: 1'b1, band: 9'h155, bias: 6'h2A};
    man_band = 9'h0AA;
    man_core = 1'b0;
    adc_code = 8'h00;
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    cyc();
    check({1'b0, settle}, 16'h0000);
    for (int i = 0; i < 16; i++) rdchk(addrs[i], 8'h00);
    endtest("reset");

    for (int i = 0; i < 16; i++) wr(addrs[i], addrs[i][7:0] ^ 8'h5A);
    for (int i = 0; i < 16; i++) rdchk(addrs[i], addrs[i][7:0] ^ 8'h5A);
    wr(15'h0043, 8'hFF);
    rdchk(15'h0043, 8'h00);
    rdchk(15'h0050, 8'h0A);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    cyc();
    rdchk(15'h003A, 8'h00);
    endtest("access");

    wr(`ADDR_SETTLE_LOW, 8'h5C);
    wr(`ADDR_SETTLE_HIGH_DELAY_BUF, 8'hAD);
    check({1'b0, settle}, 16'h2D5C);
    check({15'h0, dly_sh}, 16'h0001);
    wr(`ADDR_OUTPUT_LEVEL, 8'h20);
    check({15'h0, lvl}, 16'h0001);
    wr(`ADDR_OUTPUT_LEVEL, 8'hDF);
    check({15'h0, lvl}, 16'h0000);
    wr(`ADDR_OUTPUT_MUTE, 8'hEB);
    check({10'h0, mute2, mute1}, 16'h002B);
    endtest("fields");

    dly_in = 8'h3C;
    cyc(4);
    check({8'h0, dly_out}, 16'h0000);
    pulse_update();
    check({8'h0, dly_out}, 16'h003C);
    wr(`ADDR_SETTLE_HIGH_DELAY_BUF, 8'h2D);
    check({15'h0, dly_sh}, 16'h0000);
    dly_in = 8'hC3;
    cyc(3);
    check({8'h0, dly_out}, 16'h00C3);
    endtest("delay_buffer");

    wr(`ADDR_PTAT_TRIM, 8'hFF);
    cyc(2);
    check({10'h0, rtrim}, 16'h003F);
    wr(`ADDR_PTAT_TRIM, 8'h2A);
    cyc(2);
    check({10'h0, rtrim}, 16'h002A);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CTAT_TRIM,
         i[1] ? (i[0] ? 8'h1F : 8'h10) : (i[0] ? 8'h15 : 8'h05));
      cyc(2);
      ex = i[1] ? (i[0] ? 16'h0011 : 16'h0000) : (i[0] ? 16'h001B : 16'h0005);
      check({11'h0, ftrim}, ex);
    end
    wr(`ADDR_TEMP_OFFSET, 8'h20);
    adc_code = 8'h50;
    cyc(3);
    check({7'h0, temp}, 16'h0030);
    adc_code = 8'h10;
    cyc(3);
    check({7'h0, temp}, 16'h0110);
    endtest("trims");

    wr(`ADDR_MANUAL_BIAS, 8'hD5);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(`ADDR_VCO_OVERRIDE, {5'h00, m});
      cyc(3);
      ex = {m[0] ? man_core : cal_sel.core, m[1] ? man_band : cal_sel.band,
            m[2] ? 6'h15 : cal_sel.bias};
      check(vsel, ex);
    end
    wr(`ADDR_VTUNE_HIGH_SHADOW, 8'h80);
    pulse_update();
    man_band = 9'h1F0;
    man_core = 1'b1;
    cyc(4);
    check(vsel, {1'b0, 9'h0AA, 6'h15});
    pulse_update();
    check(vsel, {1'b1, 9'h1F0, 6'h15});
    endtest("vco_select");

    wr(`ADDR_ADC_CLK_DIV, 8'h01);
    wr(`ADDR_ADC_ENABLE, 8'h02);
    check({15'h0, adc_en}, 16'h0001);
    adc_period(1);
    wr(`ADDR_ADC_CLK_DIV, 8'h03);
    adc_period(3);
    wr(`ADDR_ADC_ENABLE, 8'h00);
    cyc(3);
    check({15'h0, adc_clk}, 16'h0000);
    endtest("adc_clock");
    report_and_stop();
  end

endmodule // tb_top

/* File: verilog/adc_clock_divider.sv */
// ADC clock generator dividing the reference by four times N plus two.
`timescale 1ns/1ps

module adc_clock_divider (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [7:0] divider_in,
  output logic adc_clk_out
);

  logic [8:0] count_q;
  logic [8:0] count_d;
  logic [8:0] half_w;
  logic toggle_w;
  logic adc_clk_q;
  logic [9:0] run_q;
  logic clean_q;
  logic [7:0] div_prev_q;

  // Each half period lasts 2N+1 cycles, so a full period is 4N+2.
  assign half_w = {divider_in, 1'b0};
  assign toggle_w = enable_in && (count_q >= half_w);
  assign count_d = (!enable_in || toggle_w) ? 9'h000 : count_q + 9'h001;

  // Divider state; the clock rests low while disabled.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 9'h000;
      adc_clk_q <= 1'b0;
    end else begin
      count_q <= count_d;
      adc_clk_q <= enable_in ? (adc_clk_q ^ toggle_w) : 1'b0;
    end
  end

  assign adc_clk_out = adc_clk_q;

  // Helper: length of the current half period, valid once undisturbed.
  // The last divider value is kept so that a rewrite marks the half dirty.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 10'h000;
      clean_q <= 1'b0;
      div_prev_q <= 8'h00;
    end else begin
      run_q <= toggle_w ? 10'h000 : run_q + 10'h001;
      div_prev_q <= divider_in;
      if (!enable_in || divider_in != div_prev_q) begin
        clean_q <= 1'b0;
      end else if (toggle_w) begin
        clean_q <= 1'b1;
      end
    end
  end

  AST_ADC_HALF_PERIOD: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    toggle_w && clean_q && divider_in == div_prev_q |->
    run_q == {1'b0, half_w})
    else $error("ADC clock half period differs from 2N+1 cycles.");

  COV_ADC_TOGGLE: cover property (@(posedge clk_in)
    disable iff (!rst_n_in) toggle_w && clean_q && divider_in != 8'h00);

endmodule // adc_clock_divider

/* File: verilog/setting_shadow.sv */
// Optional double buffer between a written setting and its active copy.
`timescale 1ns/1ps

module setting_shadow #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic shadow_en_in,
  input wire logic update_in,
  input wire logic [WIDTH-1:0] setting_in,
  output logic [WIDTH-1:0] active_out
);

  logic [WIDTH-1:0] active_q;
  logic [WIDTH-1:0] active_d;

  // Unbuffered settings follow on the next clock; buffered ones wait for the update.
  assign active_d = (!shadow_en_in || update_in) ? setting_in : active_q;

  // Active copy.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_q <= '0;
    end else begin
      active_q <= active_d;
    end
  end

  assign active_out = active_q;

endmodule // setting_shadow

/* File: verilog/vco_cal_adc_config_regs.sv */
// Register bank for VCO calibration, ADC clocking and output settings.
`timescale 1ns/1ps
`include "vco_cfg_defs.svh"

module vco_cal_adc_config_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire vco_cfg_pkg::reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic buffer_update_in,
  input wire logic [7:0] delay_ctrl_in,
  output logic [7:0] delay_ctrl_out,
  output logic delay_ctrl_shadow_en_out,
  input wire vco_cfg_pkg::vco_sel_s cal_vco_sel_in,
  input wire logic [8:0] manual_band_value_in,
  input wire logic manual_core_value_in,
  output vco_cfg_pkg::vco_sel_s vco_sel_out,
  output logic [14:0] band_core_settle_count_out,
  output logic output_logic_level_sel_out,
  output logic adc_enable_out,
  output logic adc_clk_out,
  output logic [2:0] output_one_mute_out,
  output logic [2:0] output_two_mute_out,
  output logic [5:0] cal_voltage_rising_trim_out,
  output logic signed [4:0] cal_voltage_falling_trim_out,
  input wire logic [7:0] adc_code_in,
  output logic [8:0] chip_temperature_out
);

  import vco_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Address map and storage
  // ----------------------------------------------------------------------

  localparam logic [14:0] REG_ADDR [`REG_COUNT] = '{
    `ADDR_MANUAL_BIAS, `ADDR_VTUNE_HIGH_SHADOW, `ADDR_SETTLE_LOW,
    `ADDR_SETTLE_HIGH_DELAY_BUF, `ADDR_RESERVED_LOW, `ADDR_OUTPUT_LEVEL,
    `ADDR_ADC_CLK_DIV, `ADDR_ADC_ENABLE, `ADDR_OUTPUT_MUTE,
    `ADDR_RESERVED_A, `ADDR_RESERVED_B, `ADDR_PTAT_TRIM, `ADDR_CTAT_TRIM,
    `ADDR_TEMP_OFFSET, `ADDR_VCO_OVERRIDE, `ADDR_SCRATCH
  };

  logic [7:0] regs_q [`REG_COUNT];
  logic [`REG_COUNT-1:0] hit_w;
  logic [7:0] rdata_w;
  logic [7:0] rdata_q;
  logic rvalid_q;

  // per-register decode, zero reset and full read/write
  // Reserved bits are kept as written; software owns their values.
  generate
    for (genvar i = 0; i < `REG_COUNT; i++) begin : g_reg
      assign hit_w[i] = (reg_req_in.addr == REG_ADDR[i]);
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          regs_q[i] <= `REG_RESET_VALUE;
        end else if (reg_req_in.wr && hit_w[i]) begin
          regs_q[i] <= reg_req_in.wdata;
        end
      end
    end
  endgenerate

  // Read mux; an unmapped address reads as zero.
  always_comb begin
    rdata_w = 8'h00;
    for (int j = 0; j < `REG_COUNT; j++) begin
      if (hit_w[j]) begin
        rdata_w = regs_q[j];
      end
    end
  end

  // Read data is registered and marked valid for one cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_in.rd;
      rdata_q <= reg_req_in.rd ? rdata_w : rdata_q;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------

  logic [7:0] ovr_w;
  logic manual_shadow_en_w;
  logic [7:0] ctat_w;
  logic [4:0] falling_w;
  logic [8:0] temp_diff_w;
  logic [8:0] temp_neg_w;
  logic [8:0] temp_sm_w;

  assign band_core_settle_count_out =
    {regs_q[`IDX_SETTLE_HIGH][6:0], regs_q[`IDX_SETTLE_LOW]};
  assign output_logic_level_sel_out =
    regs_q[`IDX_OUTPUT_LEVEL][`BIT_LEVEL_SEL];
  assign adc_enable_out = regs_q[`IDX_ADC_ENABLE][`BIT_ADC_EN];
  assign output_two_mute_out = regs_q[`IDX_OUTPUT_MUTE][5:3];
  assign output_one_mute_out = regs_q[`IDX_OUTPUT_MUTE][2:0];
  assign delay_ctrl_shadow_en_out =
    regs_q[`IDX_SETTLE_HIGH][`BIT_SHADOW_EN];
  assign ovr_w = regs_q[`IDX_VCO_OVERRIDE];
  assign manual_shadow_en_w =
    regs_q[`IDX_VTUNE_HIGH_SHADOW][`BIT_SHADOW_EN];

  // sign-magnitude to two's complement; negative zero gives zero
  assign ctat_w = regs_q[`IDX_CTAT_TRIM];
  assign falling_w = ctat_w[`BIT_CTAT_SIGN] ?
    5'(-{1'b0, ctat_w[3:0]}) : {1'b0, ctat_w[3:0]};

  // offset removed from the ADC code, result in sign-magnitude
  assign temp_diff_w = {1'b0, adc_code_in}
    - {1'b0, regs_q[`IDX_TEMP_OFFSET]};
  assign temp_neg_w = 9'(-temp_diff_w);
  assign temp_sm_w = temp_diff_w[8] ?
    {1'b1, temp_neg_w[7:0]} : {1'b0, temp_diff_w[7:0]};

  // Derived data outputs are registered.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_voltage_rising_trim_out <= 6'h00;
      cal_voltage_falling_trim_out <= 5'h00;
      chip_temperature_out <= 9'h000;
    end else begin
      cal_voltage_rising_trim_out <= regs_q[`IDX_PTAT_TRIM][5:0];
      cal_voltage_falling_trim_out <= falling_w;
      chip_temperature_out <= temp_sm_w;
    end
  end

  // ----------------------------------------------------------------------
  // Double-buffered settings
  // ----------------------------------------------------------------------

  vco_sel_s manual_w;
  vco_sel_s manual_active_w;
  vco_sel_s vco_sel_q;

  // manual bias comes from its own register
  assign manual_w = '{core: manual_core_value_in,
                      band: manual_band_value_in,
                      bias: regs_q[`IDX_MANUAL_BIAS][5:0]};

  // manual core, band and bias shadow
  setting_shadow #(
    .WIDTH(16)
  ) u_manual_shadow (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .shadow_en_in(manual_shadow_en_w),
    .update_in(buffer_update_in),
    .setting_in(manual_w),
    .active_out(manual_active_w)
  );

  setting_shadow #(
    .WIDTH(8)
  ) u_delay_shadow (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .shadow_en_in(delay_ctrl_shadow_en_out),
    .update_in(buffer_update_in),
    .setting_in(delay_ctrl_in),
    .active_out(delay_ctrl_out)
  );

  // Per-field choice between calibration and the manual copy.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vco_sel_q <= '0;
    end else begin
      vco_sel_q.core <= ovr_w[`BIT_CORE_OVR] ?
        manual_active_w.core : cal_vco_sel_in.core;
      vco_sel_q.band <= ovr_w[`BIT_BAND_OVR] ?
        manual_active_w.band : cal_vco_sel_in.band;
      vco_sel_q.bias <= ovr_w[`BIT_BIAS_OVR] ?
        manual_active_w.bias : cal_vco_sel_in.bias;
    end
  end

  assign vco_sel_out = vco_sel_q;

  // ----------------------------------------------------------------------
  // ADC clock
  // ----------------------------------------------------------------------

  adc_clock_divider u_adc_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(adc_enable_out),
    .divider_in(regs_q[`IDX_ADC_CLK_DIV]),
    .adc_clk_out(adc_clk_out)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_SETTLE_HIGH: assert property (
    reg_req_in.wr && reg_req_in.addr == `ADDR_SETTLE_HIGH_DELAY_BUF |=>
    band_core_settle_count_out[14:8] == $past(reg_req_in.wdata[6:0]))
    else $error("Settle count high bits not taken from the write.");

  AST_DELAY_HOLD: assert property (
    delay_ctrl_shadow_en_out && !buffer_update_in |=>
    $stable(delay_ctrl_out))
    else $error("Buffered delay control moved without an update.");

  AST_DELAY_DIRECT: assert property (
    !delay_ctrl_shadow_en_out |=> delay_ctrl_out == $past(delay_ctrl_in))
    else $error("Unbuffered delay control did not follow its input.");

  AST_LEVEL_SEL: assert property (
    reg_req_in.wr && reg_req_in.addr == `ADDR_OUTPUT_LEVEL |=>
    output_logic_level_sel_out == $past(reg_req_in.wdata[5]))
    else $error("Output level select not taken from bit 5.");

  AST_MUTE_FIELDS: assert property (
    reg_req_in.wr && reg_req_in.addr == `ADDR_OUTPUT_MUTE |=>
    {output_two_mute_out, output_one_mute_out}
      == $past(reg_req_in.wdata[5:0]))
    else $error("Mute fields not placed at bits 5:0.");

  AST_FALLING_TRIM: assert property (
    ##1 cal_voltage_falling_trim_out == ($past(ctat_w[4]) ?
      -$signed({1'b0, $past(ctat_w[3:0])}) :
      $signed({1'b0, $past(ctat_w[3:0])})))
    else $error("Falling trim sign-magnitude decode wrong.");

  AST_TEMP_SIGN: assert property (
    adc_code_in < regs_q[`IDX_TEMP_OFFSET] |=> chip_temperature_out[8])
    else $error("Temperature below offset not reported negative.");

  AST_BAND_CAL: assert property (
    !ovr_w[`BIT_BAND_OVR] |=> vco_sel_out.band == $past(cal_vco_sel_in.band))
    else $error("Band not from calibration without override.");

  AST_CORE_MANUAL: assert property (
    ovr_w[`BIT_CORE_OVR] && !manual_shadow_en_w [*2] |=>
    vco_sel_out.core == $past(manual_core_value_in, 2))
    else $error("Core not from manual field under override.");

  AST_BIAS_MANUAL: assert property (
    ovr_w[`BIT_BIAS_OVR] && !manual_shadow_en_w [*2] |=>
    vco_sel_out.bias == $past(regs_q[`IDX_MANUAL_BIAS][5:0], 2))
    else $error("Bias not from manual register under override.");

  AST_MANUAL_HOLD: assert property (
    manual_shadow_en_w && !buffer_update_in && ovr_w[`BIT_BAND_OVR] ##1
    ovr_w[`BIT_BAND_OVR] |=> $stable(vco_sel_out.band))
    else $error("Buffered manual band changed without an update.");

  AST_UNMAPPED_READ: assert property (
    reg_req_in.rd && hit_w == '0 |=> reg_rvalid_out && reg_rdata_out == 8'h00)
    else $error("Unmapped read did not return zero.");

  COV_MANUAL_UPDATE: cover property (
    manual_shadow_en_w && buffer_update_in);
  COV_BAND_OVERRIDE: cover property (
    ovr_w[`BIT_BAND_OVR] && manual_band_value_in != cal_vco_sel_in.band);
  COV_NEG_TEMP: cover property (chip_temperature_out[8]);
  COV_READ_BACK: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);

endmodule // vco_cal_adc_config_regs

/* File: verilog/vco_cfg_defs.svh */
// Offsets, field positions, reset values and counts of the VCO config bank.
`ifndef VCO_CFG_DEFS_SVH
`define VCO_CFG_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_MANUAL_BIAS 15'h0035
`define ADDR_VTUNE_HIGH_SHADOW 15'h0039
`define ADDR_SETTLE_LOW 15'h003A
`define ADDR_SETTLE_HIGH_DELAY_BUF 15'h003B
`define ADDR_RESERVED_LOW 15'h003C
`define ADDR_OUTPUT_LEVEL 15'h003D
`define ADDR_ADC_CLK_DIV 15'h003E
`define ADDR_ADC_ENABLE 15'h003F
`define ADDR_OUTPUT_MUTE 15'h0040
`define ADDR_RESERVED_A 15'h0041
`define ADDR_RESERVED_B 15'h0042
`define ADDR_PTAT_TRIM 15'h0044
`define ADDR_CTAT_TRIM 15'h0045
`define ADDR_TEMP_OFFSET 15'h004B
`define ADDR_VCO_OVERRIDE 15'h004D
`define ADDR_SCRATCH 15'h0050

// ----------------------------------------------------------------------
// Storage indices and sizes
// ----------------------------------------------------------------------
`define REG_COUNT 16
`define IDX_MANUAL_BIAS 0
`define IDX_VTUNE_HIGH_SHADOW 1
`define IDX_SETTLE_LOW 2
`define IDX_SETTLE_HIGH 3
`define IDX_OUTPUT_LEVEL 5
`define IDX_ADC_CLK_DIV 6
`define IDX_ADC_ENABLE 7
`define IDX_OUTPUT_MUTE 8
`define IDX_PTAT_TRIM 11
`define IDX_CTAT_TRIM 12
`define IDX_TEMP_OFFSET 13
`define IDX_VCO_OVERRIDE 14

// ----------------------------------------------------------------------
// Field positions and reset value
// ----------------------------------------------------------------------
`define REG_RESET_VALUE 8'h00
`define BIT_SHADOW_EN 7
`define BIT_LEVEL_SEL 5
`define BIT_ADC_EN 1
`define BIT_BIAS_OVR 2
`define BIT_BAND_OVR 1
`define BIT_CORE_OVR 0
`define BIT_CTAT_SIGN 4

`endif

/* File: verilog/vco_cfg_pkg.sv */
// Types shared by the VCO calibration and ADC configuration bank.
package vco_cfg_pkg;

  // One register access as handed over by the serial interface.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // VCO core, band and bias selection.
  typedef struct packed {
    logic core;
    logic [8:0] band;
    logic [5:0] bias;
  } vco_sel_s;

endpackage
